// [rtl/cslsc_top.sv]
// Strap capture, frequency decode, stop control and APB registers
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps

module cslsc_top
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        shared_pin_in,
   input  wire logic        cpu_halt_n_in,
   input  wire logic        pci_halt_n_in,
   input  wire logic        freq_strap_bit0_in,
   input  wire logic        freq_strap_bit1_in,
   input  wire logic        freq_strap_bit2_in,
   input  wire logic        storage_clock_select_in,
   input  wire logic        debug_port_clock_select_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic      [15:0] cpu_freq_out,
   output logic      [15:0] sata_freq_out,
   output logic      [15:0] src_freq_out,
   output logic      [15:0] pci_freq_out,
   output logic             strap_latched_out,
   output logic             fs2_pin_oe_out,
   output logic             cpu_en_out,
   output logic             pci_en_out,
   output logic             src_en_out,
   output logic             shared_en_out,
   output logic             fixed_en_out,
   output logic             ref25_en_out
);
   import cslsc_pkg::*;

   cslsc_stop_if stop_bus ();

   cslsc_state_t state_q;
   logic         wake_lan_enable_bit_q;
   logic         test_mode_q;
   logic [2:0]   fs_q;
   logic         sata_sel_q;
   logic         dbg_sel_q;
   logic         power_good_strobe;
   logic         capture;
   logic         apb_access;
   logic         apb_wr;

   assign power_good_strobe = shared_pin_in;
   // Level sampled, not edge: power-good high while waiting captures
   assign capture = power_good_strobe &&
                    (state_q == CSLSC_WAIT || test_mode_q);
   assign apb_access = psel_in && penable_in;
   assign apb_wr     = apb_access && pwrite_in;

   ////////////////////////////////////////////////////////////////////
   // Strap capture

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         state_q <= CSLSC_WAIT;
      else if (power_good_strobe)
         state_q <= CSLSC_LATCHED;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         fs_q       <= 3'h0;
         sata_sel_q <= 1'b0;
         dbg_sel_q  <= 1'b0;
      end
      else if (capture)
      begin
         fs_q       <= {freq_strap_bit2_in, freq_strap_bit1_in,
                        freq_strap_bit0_in};
         sata_sel_q <= storage_clock_select_in;
         dbg_sel_q  <= debug_port_clock_select_in;
      end
   end

   // Top strap pin turns into a clock driver once latched, except while test mode is set
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         fs2_pin_oe_out <= 1'b0;
      else
         fs2_pin_oe_out <= (state_q == CSLSC_LATCHED) && !test_mode_q;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         strap_latched_out <= 1'b0;
      else
         strap_latched_out <= (state_q == CSLSC_LATCHED);
   end

   ////////////////////////////////////////////////////////////////////
   // Frequency decode

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cpu_freq_out  <= FREQ_100_00;
         sata_freq_out <= FREQ_100_00;
         src_freq_out  <= FREQ_100_00;
         pci_freq_out  <= FREQ_33_33;
      end
      else
      begin
         case (fs_q[2:1])
            2'h0:    cpu_freq_out <= FREQ_100_00;
            2'h1:    cpu_freq_out <= FREQ_83_33;
            2'h2:    cpu_freq_out <= FREQ_133_33;
            default: cpu_freq_out <= FREQ_166_67;
         endcase
         sata_freq_out <= sata_sel_q ? FREQ_75_00 : FREQ_100_00;
         src_freq_out  <= FREQ_100_00;
         pci_freq_out  <= FREQ_33_33;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Stop control

   logic pin_low_latched;
   assign pin_low_latched = (state_q == CSLSC_LATCHED) && !shared_pin_in;
   assign stop_bus.cpu_halt = !cpu_halt_n_in;
   assign stop_bus.pci_halt = !pci_halt_n_in;
   assign stop_bus.all_halt = pin_low_latched &&
                              wake_lan_enable_bit_q;
   assign stop_bus.pwr_down = pin_low_latched &&
                              !wake_lan_enable_bit_q;
   assign stop_bus.dbg_cpu  = dbg_sel_q;

   cslsc_gate u_gate
   (
      .clk_in        (clk_sys_in),
      .rst_in        (rst_in),
      .stop          (stop_bus.gate),
      .cpu_en_out    (cpu_en_out),
      .pci_en_out    (pci_en_out),
      .src_en_out    (src_en_out),
      .shared_en_out (shared_en_out),
      .fixed_en_out  (fixed_en_out),
      .ref25_en_out  (ref25_en_out)
   );

   ////////////////////////////////////////////////////////////////////
   // APB registers

   // Write lands on the edge that completes the access
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         wake_lan_enable_bit_q <= CTRL_WOL_RST;
         test_mode_q           <= CTRL_TEST_RST;
      end
      else if (apb_wr && pready_out && paddr_in == ADDR_CTRL)
      begin
         wake_lan_enable_bit_q <= pwdata_in[CTRL_WOL_BIT];
         test_mode_q           <= pwdata_in[CTRL_TEST_BIT];
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         pready_out <= 1'b0;
      else
         pready_out <= psel_in && penable_in && !pready_out;
   end

   // Unmapped address answers with slave error
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         prdata_out  <= 32'h0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         prdata_out  <= 32'h0;
         pslverr_out <= 1'b0;
         if (apb_access && !pready_out)
         begin
            if (paddr_in == ADDR_CTRL)
               prdata_out <= {30'h0, test_mode_q, wake_lan_enable_bit_q};
            else if (paddr_in == ADDR_STRAP)
               prdata_out <= {23'h0, state_q == CSLSC_LATCHED, 2'h0,
                              dbg_sel_q, sata_sel_q, 1'b0, fs_q};
            else if (paddr_in == ADDR_CPUF)
               prdata_out <= {16'h0, cpu_freq_out};
            else if (paddr_in == ADDR_SATAF)
               prdata_out <= {16'h0, sata_freq_out};
            else if (paddr_in == ADDR_STATUS)
               prdata_out <= {26'h0, ref25_en_out, fixed_en_out,
                              shared_en_out, src_en_out, pci_en_out,
                              cpu_en_out};
            else
               pslverr_out <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions

   property p_cpu_stop;
      @(posedge clk_sys_in) disable iff (rst_in)
      !cpu_halt_n_in |=> !cpu_en_out;
   endproperty
   a_cpu_stop: assert property (p_cpu_stop)
      else $error("cpu outputs run while halted");

   property p_pci_stop;
      @(posedge clk_sys_in) disable iff (rst_in)
      !pci_halt_n_in |=> !pci_en_out && !src_en_out;
   endproperty
   a_pci_stop: assert property (p_pci_stop)
      else $error("pci or src run while halted");

   property p_cpu_only;
      @(posedge clk_sys_in) disable iff (rst_in)
      (!cpu_halt_n_in && pci_halt_n_in && shared_pin_in) |=> pci_en_out;
   endproperty
   a_cpu_only: assert property (p_cpu_only)
      else $error("cpu halt stopped pci");

   property p_wol_stop;
      @(posedge clk_sys_in) disable iff (rst_in)
      (pin_low_latched && wake_lan_enable_bit_q)
         |=> !fixed_en_out && ref25_en_out;
   endproperty
   a_wol_stop: assert property (p_wol_stop)
      else $error("wake stop gating wrong");

   property p_pdown;
      @(posedge clk_sys_in) disable iff (rst_in)
      (pin_low_latched && !wake_lan_enable_bit_q) |=> !ref25_en_out;
   endproperty
   a_pdown: assert property (p_pdown)
      else $error("power down did not stop reference");

   property p_cpu_freq;
      @(posedge clk_sys_in) disable iff (rst_in)
      (fs_q[2:1] == 2'h2) |=> cpu_freq_out == FREQ_133_33;
   endproperty
   a_cpu_freq: assert property (p_cpu_freq)
      else $error("cpu frequency decode wrong");

   property p_sata_freq;
      @(posedge clk_sys_in) disable iff (rst_in)
      sata_sel_q |=> sata_freq_out == FREQ_75_00;
   endproperty
   a_sata_freq: assert property (p_sata_freq)
      else $error("sata frequency decode wrong");

   property p_one_shot;
      @(posedge clk_sys_in) disable iff (rst_in)
      (state_q == CSLSC_LATCHED && !test_mode_q) |=> $stable(fs_q);
   endproperty
   a_one_shot: assert property (p_one_shot)
      else $error("straps changed after capture");

   property p_sample;
      @(posedge clk_sys_in) disable iff (rst_in)
      (state_q == CSLSC_WAIT && power_good_strobe) |=>
         fs_q == $past({freq_strap_bit2_in, freq_strap_bit1_in,
                        freq_strap_bit0_in}) ##1 strap_latched_out;
   endproperty
   a_sample: assert property (p_sample)
      else $error("straps not sampled on power good");

   property p_fs2_oe;
      @(posedge clk_sys_in) disable iff (rst_in)
      (state_q == CSLSC_WAIT) |=> !fs2_pin_oe_out;
   endproperty
   a_fs2_oe: assert property (p_fs2_oe)
      else $error("strap pin driven before capture");

   property p_wol_reset;
      @(posedge clk_sys_in)
      rst_in |=> wake_lan_enable_bit_q;
   endproperty
   a_wol_reset: assert property (p_wol_reset)
      else $error("wake enable not one after reset");

   property p_shared_cpu;
      @(posedge clk_sys_in) disable iff (rst_in)
      (dbg_sel_q && !cpu_halt_n_in) |=> !shared_en_out;
   endproperty
   a_shared_cpu: assert property (p_shared_cpu)
      else $error("shared pair ignored cpu halt");

   property p_shared_src;
      @(posedge clk_sys_in) disable iff (rst_in)
      (!dbg_sel_q && !pci_halt_n_in) |=> !shared_en_out;
   endproperty
   a_shared_src: assert property (p_shared_src)
      else $error("shared pair ignored src halt");

   property p_test_cap;
      @(posedge clk_sys_in) disable iff (rst_in)
      (test_mode_q && power_good_strobe) |=>
         fs_q == $past({freq_strap_bit2_in, freq_strap_bit1_in,
                        freq_strap_bit0_in});
   endproperty
   a_test_cap: assert property (p_test_cap)
      else $error("test mode did not recapture straps");

   property p_fs2_on;
      @(posedge clk_sys_in) disable iff (rst_in)
      (state_q == CSLSC_LATCHED && !test_mode_q) |=> fs2_pin_oe_out;
   endproperty
   a_fs2_on: assert property (p_fs2_on)
      else $error("strap pin not driven after capture");

   property p_fixed_freq;
      @(posedge clk_sys_in) disable iff (rst_in)
      pci_freq_out == FREQ_33_33 && src_freq_out == FREQ_100_00;
   endproperty
   a_fixed_freq: assert property (p_fixed_freq)
      else $error("pci or src frequency not fixed");

   c_capture: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      state_q == CSLSC_WAIT ##1 state_q == CSLSC_LATCHED);
   c_wol: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      pin_low_latched && wake_lan_enable_bit_q);
   c_pdown: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      pin_low_latched && !wake_lan_enable_bit_q);
   c_read: cover property (@(posedge clk_sys_in) disable iff (rst_in)
      apb_access && pready_out && !pwrite_in);
endmodule

// [rtl/cslsc_pkg.sv]
// Package of constants and types for the clock strap latch and stop control
package cslsc_pkg;
   // Frequency codes, in units of 10 kHz
   localparam logic [15:0] FREQ_100_00 = 16'h2710;
   localparam logic [15:0] FREQ_83_33  = 16'h208d;
   localparam logic [15:0] FREQ_133_33 = 16'h3415;
   localparam logic [15:0] FREQ_166_67 = 16'h411b;
   localparam logic [15:0] FREQ_75_00  = 16'h1d4c;
   localparam logic [15:0] FREQ_33_33  = 16'h0d05;

   // APB register byte offsets
   localparam logic [11:0] ADDR_CTRL   = 12'h000;
   localparam logic [11:0] ADDR_STRAP  = 12'h004;
   localparam logic [11:0] ADDR_CPUF   = 12'h008;
   localparam logic [11:0] ADDR_SATAF  = 12'h00c;
   localparam logic [11:0] ADDR_STATUS = 12'h010;

   // Control register fields
   localparam int CTRL_WOL_BIT  = 0;
   localparam int CTRL_TEST_BIT = 1;
   localparam logic CTRL_WOL_RST  = 1'b1;
   localparam logic CTRL_TEST_RST = 1'b0;

   // Strap register fields
   localparam int STRAP_FS0  = 0;
   localparam int STRAP_FS1  = 1;
   localparam int STRAP_FS2  = 2;
   localparam int STRAP_SATA = 4;
   localparam int STRAP_DBG  = 5;
   localparam int STRAP_DONE = 8;

   typedef enum logic [1:0] {
      CSLSC_WAIT,
      CSLSC_LATCHED
   } cslsc_state_t;
endpackage

// [rtl/cslsc_stop_if.sv]
// Interface carrying stop requests from the top to the gating module
`timescale 1ns/10ps
interface cslsc_stop_if;
   logic cpu_halt;
   logic pci_halt;
   logic all_halt;
   logic pwr_down;
   logic dbg_cpu;

   modport ctrl
   (
      output cpu_halt,
      output pci_halt,
      output all_halt,
      output pwr_down,
      output dbg_cpu
   );
   modport gate
   (
      input  cpu_halt,
      input  pci_halt,
      input  all_halt,
      input  pwr_down,
      input  dbg_cpu
   );
endinterface

// [rtl/cslsc_gate.sv]
// Output enable gating for the clock output groups
`timescale 1ns/10ps
module cslsc_gate
(
   input  wire logic  clk_in,
   input  wire logic  rst_in,
   cslsc_stop_if.gate stop,
   output logic       cpu_en_out,
   output logic       pci_en_out,
   output logic       src_en_out,
   output logic       shared_en_out,
   output logic       fixed_en_out,
   output logic       ref25_en_out
);
   import cslsc_pkg::*;

   logic any_off;
   logic cpu_on;
   logic src_on;
   assign any_off = stop.all_halt | stop.pwr_down;
   assign cpu_on  = !any_off && !stop.cpu_halt;
   assign src_on  = !any_off && !stop.pci_halt;

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         cpu_en_out    <= 1'b0;
         pci_en_out    <= 1'b0;
         src_en_out    <= 1'b0;
         shared_en_out <= 1'b0;
         fixed_en_out  <= 1'b0;
         ref25_en_out  <= 1'b0;
      end
      else
      begin
         cpu_en_out    <= cpu_on;
         pci_en_out    <= src_on;
         src_en_out    <= src_on;
         shared_en_out <= stop.dbg_cpu ? cpu_on : src_on;
         fixed_en_out  <= !any_off;
         ref25_en_out  <= !stop.pwr_down;
      end
   end
endmodule

// [tb/cslsc_platform.sv]
// Platform model driving straps, power-good/stop pin and halt inputs
`timescale 1ns/10ps
module cslsc_platform
(
   input  wire logic       clk_in,
   input  wire logic [4:0] cfg_in,
   input  wire logic       pg_in,
   input  wire logic       cpu_run_in,
   input  wire logic       pci_run_in,
   output logic      [4:0] strap_out,
   output logic            pin_out,
   output logic            cpu_halt_n_out,
   output logic            pci_halt_n_out
);
   initial
   begin
      strap_out = 5'h00;
      pin_out = 1'b0;
      cpu_halt_n_out = 1'b1;
      pci_halt_n_out = 1'b1;
   end

   // Power-good only once straps have settled for a cycle
   always @(posedge clk_in)
   begin
      strap_out      <= cfg_in;
      pin_out        <= pg_in && (strap_out == cfg_in);
      cpu_halt_n_out <= cpu_run_in;
      pci_halt_n_out <= pci_run_in;
   end
endmodule

// [tb/tb_clock_strap_latch_and_stop_control.sv]
// Testbench for strap capture, frequency decode and stop control
`timescale 1ns/10ps
module tb_clock_strap_latch_and_stop_control;
   import cslsc_pkg::*;
   localparam logic [15:0] CPU_TAB [4] =
      '{FREQ_100_00, FREQ_83_33, FREQ_133_33, FREQ_166_67};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        pg = 1'b0;
   logic        cpu_run = 1'b1;
   logic        pci_run = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0;
   logic [4:0]  cfg = 5'h00;
   logic [4:0]  strap;
   logic        pin, cpu_n, pci_n, pready, pslverr, latched, oe, er;
   logic [31:0] prdata, rd;
   logic [15:0] cpuf, sataf, srcf, pcif;
   logic        en_cpu, en_pci, en_src, en_sh, en_fix, en_ref;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   cslsc_platform u_plat
   (
      .clk_in(clk), .cfg_in(cfg), .pg_in(pg), .cpu_run_in(cpu_run),
      .pci_run_in(pci_run), .strap_out(strap), .pin_out(pin),
      .cpu_halt_n_out(cpu_n), .pci_halt_n_out(pci_n)
   );

   cslsc_top dut_u
   (
      .clk_sys_in(clk), .rst_in(rst), .shared_pin_in(pin),
      .cpu_halt_n_in(cpu_n), .pci_halt_n_in(pci_n),
      .freq_strap_bit0_in(strap[0]), .freq_strap_bit1_in(strap[1]),
      .freq_strap_bit2_in(strap[2]), .storage_clock_select_in(strap[3]),
      .debug_port_clock_select_in(strap[4]), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .cpu_freq_out(cpuf), .sata_freq_out(sataf), .src_freq_out(srcf),
      .pci_freq_out(pcif), .strap_latched_out(latched),
      .fs2_pin_oe_out(oe), .cpu_en_out(en_cpu), .pci_en_out(en_pci),
      .src_en_out(en_src), .shared_en_out(en_sh), .fixed_en_out(en_fix),
      .ref25_en_out(en_ref)
   );

   ////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      chk(n, 32'h2);
   endtask

   task do_reset;
      @(posedge clk);
      rst <= 1'b1;
      pg <= 1'b0;
      tick(20);
      rst <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      tick(2);
      chk({16'h0, cpuf}, {16'h0, FREQ_100_00});
      chk({16'h0, pcif}, {16'h0, FREQ_33_33});
      chk({31'h0, latched}, 32'h0);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, ADDR_CPUF, 32'h1234);
      apb(1'b0, ADDR_CPUF, 32'h0);
      chk(rd, {16'h0, FREQ_100_00});
      apb(1'b0, 12'h014, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test reset done");
   endtask

   task t_cap(input logic [4:0] c);
      int n;
      do_reset;
      cfg <= c;
      pg <= 1'b1;
      n = 0;
      while (latched !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      tick(1);
      chk({16'h0, cpuf}, {16'h0, CPU_TAB[c[2:1]]});
      chk({16'h0, sataf}, {16'h0, c[3] ? FREQ_75_00 : FREQ_100_00});
      chk({16'h0, srcf}, {16'h0, FREQ_100_00});
      chk({16'h0, pcif}, {16'h0, FREQ_33_33});
      chk({31'h0, oe}, 32'h1);
      chk({31'h0, en_ref}, 32'h1);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h3f);
      cpu_run <= 1'b0;
      tick(3);
      chk({31'h0, en_sh}, {31'h0, ~c[4]});
      cpu_run <= 1'b1;
      tick(3);
      apb(1'b0, ADDR_STRAP, 32'h0);
      chk(rd, {23'h0, 1'b1, 2'b00, c[4:3], 1'b0, c[2:0]});
      $display("test capture %h done", c);
   endtask

   task t_oneshot;
      cfg <= 5'h00;
      pg <= 1'b0;
      tick(4);
      pg <= 1'b1;
      tick(4);
      chk({16'h0, cpuf}, {16'h0, FREQ_166_67});
      apb(1'b1, ADDR_CTRL, 32'h3);
      tick(4);
      chk({16'h0, cpuf}, {16'h0, FREQ_100_00});
      chk({31'h0, oe}, 32'h0);
      $display("test one-shot done");
   endtask

   task t_stop;
      cpu_run <= 1'b0;
      tick(4);
      chk({29'h0, en_cpu, en_pci, en_src}, 32'h3);
      cpu_run <= 1'b1;
      pci_run <= 1'b0;
      tick(4);
      chk({28'h0, en_cpu, en_pci, en_src, en_sh}, 32'h8);
      pci_run <= 1'b1;
      pg <= 1'b0;
      tick(4);
      chk({29'h0, en_cpu, en_fix, en_ref}, 32'h1);
      pg <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0);
      pg <= 1'b0;
      tick(4);
      chk({30'h0, en_fix, en_ref}, 32'h0);
      pg <= 1'b1;
      $display("test stops done");
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_total++;
         final_report;
      end
   end

   initial
   begin
      tick(20);
      rst <= 1'b0;
      t_reset;
      t_cap(5'b01001);
      t_cap(5'b10010);
      t_cap(5'b00100);
      t_cap(5'b11111);
      t_oneshot;
      t_cap(5'b00000);
      t_stop;
      final_report;
   end
endmodule
